// ==== cig_hold.sv ====
module cig_hold
  import cig_pkg::*;
#(
  parameter int W = 3
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic pass_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] held_q;
  // reset value is supply off, reset asserted
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      held_q <= '1;
    end else if (en_i && pass_i) begin
      held_q <= d_i;
    end
  end
  // transparent while passing, else held copy
  assign q_o = pass_i ? d_i : held_q;
endmodule : cig_hold

// ==== cig_line_model.sv ====
module cig_line_model (
  input wire logic [5:0] oe_i,
  input wire logic [5:0] o_i,
  input wire logic [5:0] ext_low_i,
  output logic [5:0] line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // bits 2:0 host io, aux a, aux b; bits 5:3 card io, aux a, aux b
  // open drain with pull-up: any party pulling low wins, released line reads high
  // pull-up on released lines
  assign line_o = ~(ext_low_i | (oe_i & ~o_i));
endmodule : cig_line_model

// ==== cig_pkg.sv ====
package cig_pkg;
  // supply selection codes {hi_n, mid_n}
  localparam logic [1:0] SEL_1V8 = 2'h0;
  localparam logic [1:0] SEL_5V0 = 2'h1;
  localparam logic [1:0] SEL_3V0 = 2'h2;
  localparam logic [1:0] SEL_OFF = 2'h3;
  // register offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  // ctrl fields
  localparam int CTRL_FAULT_BIT = 0;
  localparam int CTRL_PWR_GOOD_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // irq fields
  localparam int IRQ_CARD_PRESENT_SENSE_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h3;
  // supply ramp time and cycles at 250 MHz
  localparam int RAMP_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int RAMP_CYCLES = (RAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    SEQ_OFF = 2'b00,
    SEQ_RAMP = 2'b01,
    SEQ_ON = 2'b10
  } cig_seq_t;

  function automatic logic sel_active(input logic [1:0] sel);
    sel_active = (sel != SEL_OFF);
  endfunction : sel_active
endpackage : cig_pkg

// ==== cig_seq.sv ====
module cig_seq
  import cig_pkg::*;
#(
  parameter int RAMP = RAMP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic want_i,
  input wire logic kill_i,
  output logic power_o,
  output logic ready_o
);
  cig_seq_t st_q;
  logic [15:0] cnt_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= SEQ_OFF;
      cnt_q <= 16'h0000;
    end else if (en_i) begin
      unique case (st_q)
        SEQ_OFF: begin
          cnt_q <= 16'h0000;
          if (want_i && !kill_i) begin
            st_q <= SEQ_RAMP;
          end
        end
        SEQ_RAMP: begin
          cnt_q <= cnt_q + 16'h0001;
          if (!want_i || kill_i) begin
            st_q <= SEQ_OFF;
          end else if (cnt_q == 16'(RAMP - 1)) begin
            st_q <= SEQ_ON;
          end
        end
        SEQ_ON: begin
          if (!want_i || kill_i) begin
            st_q <= SEQ_OFF;
          end
        end
        default: st_q <= SEQ_OFF;
      endcase
    end
  end
  assign power_o = (st_q != SEQ_OFF);
  assign ready_o = (st_q == SEQ_ON);
endmodule : cig_seq

// ==== cig_top.sv ====
// Notes on behaviour
// - select high passes host inputs through
// - select low holds supply and reset
// - select low floats host data lines
// - select low disables ready and interrupt
// - interrupt is open drain, active low
// - interrupt pull-up off in low power
// - high presence input means inserted
// - low presence input means inserted
// - card clock follows clock source input while powered
// - card power driven by the sequencer
// - two active-low selects pick supply voltage
// - host reset reflected onto card reset while powered
// - ready once supply ramped after select
module cig_top
  import cig_pkg::*;
#(
  parameter int RAMP = RAMP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic chip_sel_i,
  input wire logic supply_sel_hi_n_i,
  input wire logic supply_sel_mid_n_i,
  input wire logic host_card_reset_in_i,
  input wire logic low_power_request_i,
  input wire logic card_present_sense_hi_i,
  input wire logic card_present_sense_lo_n_i,
  input wire logic card_clock_source_i,
  input wire logic fault_i,
  input wire logic host_card_io_i,
  output logic host_card_io_o,
  output logic host_card_io_oe_o,
  output logic host_card_io_pu_o,
  input wire logic host_aux_line_a_i,
  output logic host_aux_line_a_o,
  output logic host_aux_line_a_oe_o,
  input wire logic host_aux_line_b_i,
  output logic host_aux_line_b_o,
  output logic host_aux_line_b_oe_o,
  input wire logic card_io_i,
  output logic card_io_o,
  output logic card_io_oe_o,
  input wire logic card_aux_line_a_i,
  output logic card_aux_line_a_o,
  output logic card_aux_line_a_oe_o,
  input wire logic card_aux_line_b_i,
  output logic card_aux_line_b_o,
  output logic card_aux_line_b_oe_o,
  output logic card_reset_o,
  output logic card_clock_o,
  output logic card_power_o,
  output logic [1:0] supply_level_o,
  output logic low_power_o,
  output logic ready_o,
  output logic ready_oe_o,
  output logic ready_pu_o,
  output logic irq_n_o,
  output logic irq_n_oe_o,
  output logic irq_pu_o,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o
);
  logic [2:0] held;
  logic sel_hi_n;
  logic sel_mid_n;
  logic rst_held;
  logic want;
  logic seq_pwr;
  logic seq_rdy;
  logic present;
  logic card_present_sense_q;
  logic fault_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_set;
  logic [7:0] ctrl_q;
  logic lp_q;
  logic irq_any;
  logic [7:0] rdata_q;
  logic [2:0] host_ln;
  logic [2:0] card_ln;
  logic link_on;
  logic [2:0] h2c_q;
  logic [2:0] c2h_q;

  cig_hold #(.W(3)) u_hold (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(ce_i),
    .pass_i(chip_sel_i),
    .d_i({supply_sel_hi_n_i, supply_sel_mid_n_i, host_card_reset_in_i}),
    .q_o(held)
  );
  assign sel_hi_n = held[2];
  assign sel_mid_n = held[1];
  assign rst_held = held[0];

  assign supply_level_o = {sel_hi_n, sel_mid_n};
  assign want = sel_active({sel_hi_n, sel_mid_n}) && !lp_q;

  // low power only when no supply selected
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lp_q <= 1'b0;
    end else if (ce_i) begin
      lp_q <= low_power_request_i && !sel_active({sel_hi_n, sel_mid_n});
    end
  end
  assign low_power_o = lp_q;

  // sequencer owns card power and ready
  cig_seq #(.RAMP(RAMP)) u_seq (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(ce_i),
    .want_i(want),
    .kill_i(fault_i || ctrl_q[CTRL_FAULT_BIT]),
    .power_o(seq_pwr),
    .ready_o(seq_rdy)
  );
  assign card_power_o = seq_pwr;

  // reset reflected, held low without power
  assign card_reset_o = rst_held && seq_pwr;
  // card clock gated by power, follows source
  assign card_clock_o = card_clock_source_i && seq_pwr;

  // bit 0 io, bit 1 aux a, bit 2 aux b
  assign host_ln = {host_aux_line_b_i, host_aux_line_a_i, host_card_io_i};
  assign card_ln = {card_aux_line_b_i, card_aux_line_a_i, card_io_i};
  assign link_on = chip_sel_i && seq_pwr;

  // low-only repeaters, one owner
  // side that pulled first owns the line; if both sides pull in the same cycle, neither pull-down latches
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      h2c_q <= 3'h0;
      c2h_q <= 3'h0;
    end else if (ce_i) begin
      for (int k = 0; k < 3; k++) begin
        h2c_q[k] <= link_on && !host_ln[k] && (h2c_q[k] || (!c2h_q[k] && card_ln[k]));
        c2h_q[k] <= link_on && !card_ln[k] && (c2h_q[k] || (!h2c_q[k] && host_ln[k]));
      end
    end
  end

  // host side floats with pull-up when deselected
  assign host_card_io_pu_o = 1'b1;
  assign host_card_io_o = 1'b0;
  assign host_card_io_oe_o = link_on && c2h_q[0];
  assign host_aux_line_a_o = 1'b0;
  assign host_aux_line_a_oe_o = link_on && c2h_q[1];
  assign host_aux_line_b_o = 1'b0;
  assign host_aux_line_b_oe_o = link_on && c2h_q[2];
  // open-drain style toward the card, low only
  assign card_io_o = 1'b0;
  assign card_io_oe_o = link_on && h2c_q[0];
  assign card_aux_line_a_o = 1'b0;
  assign card_aux_line_a_oe_o = link_on && h2c_q[1];
  assign card_aux_line_b_o = 1'b0;
  assign card_aux_line_b_oe_o = link_on && h2c_q[2];

  assign present = card_present_sense_hi_i || !card_present_sense_lo_n_i;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      card_present_sense_q <= 1'b0;
      fault_q <= 1'b0;
    end else if (ce_i) begin
      card_present_sense_q <= present;
      fault_q <= fault_i;
    end
  end
  assign irq_set[IRQ_CARD_PRESENT_SENSE_BIT] = present != card_present_sense_q;
  assign irq_set[IRQ_FAULT_BIT] = fault_i && !fault_q;

  // sticky events, read clears, set wins over clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_stat_q <= 2'h0;
    end else if (ce_i) begin
      if (rd_i && addr_i == ADDR_IRQ_STAT) begin
        irq_stat_q <= irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_mask_q <= IRQ_MASK_RESET;
      ctrl_q <= CTRL_RESET;
    end else if (ce_i && wr_i) begin
      if (addr_i == ADDR_IRQ_MASK) begin
        irq_mask_q <= wdata_i[1:0];
      end
      if (addr_i == ADDR_CTRL) begin
        ctrl_q <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      rdata_q <= 8'h00;
      if (rd_i) begin
        unique case (addr_i)
          ADDR_CTRL: rdata_q <= ctrl_q;
          ADDR_STATUS: rdata_q <= {2'h0, lp_q, present, seq_rdy, seq_pwr, sel_hi_n, sel_mid_n};
          ADDR_IRQ_STAT: rdata_q <= {6'h00, irq_stat_q};
          ADDR_IRQ_MASK: rdata_q <= {6'h00, irq_mask_q};
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end
  assign rdata_o = rdata_q;

  assign irq_any = |(irq_stat_q & irq_mask_q) || (fault_i && !ctrl_q[CTRL_PWR_GOOD_BIT]);

  // open drain interrupt, low only when selected
  assign irq_n_o = 1'b0;
  assign irq_n_oe_o = chip_sel_i && irq_any;
  // pull-up dropped in low power or deselect
  assign irq_pu_o = chip_sel_i && !lp_q;
  assign ready_o = seq_rdy;
  assign ready_oe_o = chip_sel_i;
  assign ready_pu_o = chip_sel_i && !lp_q;

  property p_ready_ramp;
    @(posedge clk_i) disable iff (!rstn_i)
      $rose(seq_rdy) |-> $past(seq_pwr) && $past(want);
  endproperty
  a_ready_ramp: assert property (p_ready_ramp) else $error("ready without ramp");
  property p_desel;
    @(posedge clk_i) disable iff (!rstn_i)
      !chip_sel_i |-> !irq_n_oe_o && !ready_oe_o && !irq_pu_o && !ready_pu_o;
  endproperty
  a_desel: assert property (p_desel) else $error("output driven while deselected");
  property p_float;
    @(posedge clk_i) disable iff (!rstn_i)
      !chip_sel_i |-> !host_card_io_oe_o && !card_io_oe_o && !host_aux_line_a_oe_o;
  endproperty
  a_float: assert property (p_float) else $error("data passed while deselected");
  property p_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      !chip_sel_i && $past(!chip_sel_i) |-> $stable(held);
  endproperty
  a_hold: assert property (p_hold) else $error("held controls changed");
  property p_pass;
    @(posedge clk_i) disable iff (!rstn_i)
      chip_sel_i |-> held == {supply_sel_hi_n_i, supply_sel_mid_n_i, host_card_reset_in_i};
  endproperty
  a_pass: assert property (p_pass) else $error("controls not passed");
  // low power refused with supply selected
  property p_lp;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && sel_active({sel_hi_n, sel_mid_n}) |=> !lp_q;
  endproperty
  a_lp: assert property (p_lp) else $error("low power taken while selected");
  property p_card_present_sense;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && (present != card_present_sense_q) |=> irq_stat_q[IRQ_CARD_PRESENT_SENSE_BIT];
  endproperty
  a_card_present_sense: assert property (p_card_present_sense) else $error("presence change lost");
  property p_pwr;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && !want |=> !seq_pwr;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power on without request");
endmodule : cig_top

// ==== cig_top_tb.sv ====
module cig_top_tb;
  import cig_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rstn_i = 0, cs = 1, hi_n = 1, mid_n = 1, rst_in = 0, lp = 0, ce = 1;
  logic card_present_sense_hi = 0, card_present_sense_lo_n = 1, src = 0, fault = 0, wr_i = 0, rd_i = 0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [5:0] ext_low = 6'h00;
  logic [5:0] oe, o, ln;
  logic [1:0] supply_level_o;
  logic [7:0] rdata_o;
  logic io_pu, card_reset_o, card_clock_o, card_power_o, low_power_o;
  logic ready_o, ready_oe_o, ready_pu_o, irq_n_o, irq_n_oe_o, irq_pu_o;
  int error_cnt = 0;
  int checked = 0;
  int n = 0;
  localparam int RAMP_SIM = 4;
  // pin pairs {hi_n, mid_n} and the supply each one selects
  logic [1:0] pin_tab [4] = '{2'h3, 2'h0, 2'h1, 2'h2};
  logic [1:0] lvl_tab [4] = '{SEL_OFF, SEL_1V8, SEL_5V0, SEL_3V0};

  always #2 clk_i = ~clk_i;

  cig_top #(.RAMP(RAMP_SIM)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .chip_sel_i(cs),
    .supply_sel_hi_n_i(hi_n), .supply_sel_mid_n_i(mid_n), .host_card_reset_in_i(rst_in),
    .low_power_request_i(lp), .card_present_sense_hi_i(card_present_sense_hi),
    .card_present_sense_lo_n_i(card_present_sense_lo_n), .card_clock_source_i(src), .fault_i(fault),
    .host_card_io_i(ln[0]), .host_card_io_o(o[0]), .host_card_io_oe_o(oe[0]),
    .host_card_io_pu_o(io_pu),
    .host_aux_line_a_i(ln[1]), .host_aux_line_a_o(o[1]), .host_aux_line_a_oe_o(oe[1]),
    .host_aux_line_b_i(ln[2]), .host_aux_line_b_o(o[2]), .host_aux_line_b_oe_o(oe[2]),
    .card_io_i(ln[3]), .card_io_o(o[3]), .card_io_oe_o(oe[3]),
    .card_aux_line_a_i(ln[4]), .card_aux_line_a_o(o[4]), .card_aux_line_a_oe_o(oe[4]),
    .card_aux_line_b_i(ln[5]), .card_aux_line_b_o(o[5]), .card_aux_line_b_oe_o(oe[5]),
    .card_reset_o(card_reset_o), .card_clock_o(card_clock_o), .card_power_o(card_power_o),
    .supply_level_o(supply_level_o), .low_power_o(low_power_o), .ready_o(ready_o),
    .ready_oe_o(ready_oe_o), .ready_pu_o(ready_pu_o), .irq_n_o(irq_n_o),
    .irq_n_oe_o(irq_n_oe_o), .irq_pu_o(irq_pu_o), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o)
  );

  cig_line_model line_u (.oe_i(oe), .o_i(o), .ext_low_i(ext_low), .line_o(ln));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic pause(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : pause

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 0;
    #1;
    chk(rdata_o, e);
  endtask : rd

  task automatic complete_run;
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  initial begin
    #20000;
    error_cnt++;
    complete_run;
  end

  initial begin
    pause(16);
    rstn_i = 1;
    pause(1);
    chk(card_power_o, 0);
    rd(ADDR_IRQ_MASK, {6'h00, IRQ_MASK_RESET});
    rd(ADDR_CTRL, CTRL_RESET);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    rd(ADDR_CTRL, CTRL_RESET);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      {hi_n, mid_n} <= pin_tab[i];
      pause(1);
      chk(supply_level_o, 8'(lvl_tab[i]));
    end
    for (int i = 0; i < 40 && ready_o !== 1'b1; i++) pause(1);
    chk(ready_o, 1);
    chk(card_power_o, 1);
    chk(ready_pu_o, 1);
    chk(irq_pu_o, 1);
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk_i);
      src <= 1'(v);
      pause(1);
      chk(card_clock_o, 8'(v));
    end
    @(posedge clk_i);
    rst_in <= 1;
    pause(1);
    chk(card_reset_o, 1);
    ext_low <= 6'h07;
    pause(1);
    chk(ln[5:3], 8'h00);
    // one cycle to drop the old owner, one to take the new
    ext_low <= 6'h38;
    pause(2);
    chk(ln[2:0], 8'h00);
    // select low: supply and reset must stay frozen
    cs <= 0;
    pause(1);
    {hi_n, mid_n, rst_in, card_present_sense_hi} <= 4'hd;
    ext_low <= 6'h07;
    pause(2);
    chk(supply_level_o, SEL_3V0);
    chk(card_reset_o, 1);
    chk(ln[5:3], 8'h07);
    chk(io_pu, 1);
    ext_low <= 6'h38;
    pause(1);
    chk(ln[2:0], 8'h07);
    chk({ready_oe_o, ready_pu_o, irq_n_oe_o}, 8'h00);
    chk(irq_pu_o, 0);
    // select raised before any read of ready or interrupt
    // select before read
    {cs, hi_n, mid_n, rst_in} <= 4'hc;
    ext_low <= 6'h00;
    pause(2);
    chk(ln, 8'h3f);
    chk(irq_n_oe_o, 1);
    chk(irq_n_o, 0);
    rd(ADDR_STATUS, 8'h1e);
    rd(ADDR_IRQ_STAT, 8'h01);
    rd(ADDR_IRQ_STAT, 8'h00);
    chk(irq_n_oe_o, 0);
    wr(ADDR_IRQ_MASK, 8'h00);
    card_present_sense_hi <= 0;
    pause(2);
    chk(irq_n_oe_o, 0);
    rd(ADDR_STATUS, 8'h0e);
    rd(ADDR_IRQ_STAT, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h03);
    card_present_sense_lo_n <= 0;
    pause(2);
    chk(irq_n_oe_o, 1);
    rd(ADDR_STATUS, 8'h1e);
    rd(ADDR_IRQ_STAT, 8'h01);
    fault <= 1;
    pause(2);
    chk(card_power_o, 0);
    chk(irq_n_oe_o, 1);
    fault <= 0;
    n = 0;
    while (ready_o !== 1'b1 && n < 50) begin
      pause(1);
      n++;
    end
    // one cycle to leave off, then the ramp count
    chk(8'(n), 8'(RAMP_SIM + 1));
    rd(ADDR_IRQ_STAT, 8'h02);
    chk(irq_n_oe_o, 0);
    wr(ADDR_CTRL, 8'h01);
    pause(1);
    chk(card_power_o, 0);
    rd(ADDR_CTRL, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h00);
    wr(ADDR_CTRL, 8'h02);
    fault <= 1;
    pause(2);
    chk(irq_n_oe_o, 0);
    fault <= 0;
    wr(ADDR_IRQ_MASK, 8'h03);
    pause(1);
    chk(irq_n_oe_o, 1);
    rd(ADDR_IRQ_STAT, 8'h02);
    wr(ADDR_CTRL, CTRL_RESET);
    lp <= 1;
    pause(2);
    chk(low_power_o, 0);
    chk(irq_pu_o, 1);
    {hi_n, mid_n} <= SEL_OFF;
    pause(3);
    chk(low_power_o, 1);
    chk({ready_pu_o, irq_pu_o}, 8'h00);
    // clock enable low freezes the low-power flag
    ce <= 0;
    lp <= 0;
    pause(2);
    chk(low_power_o, 1);
    ce <= 1;
    pause(2);
    chk(low_power_o, 0);
    complete_run;
  end
endmodule : cig_top_tb
